/* inc/rts_defines.svh */
/*
 * shared constants of the tag select / family id command handler.
 * assumes inclusion by bare name from design files.
 */
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
// ************************
// commands and flags
// ************************
`define RTS_CMD_SELECT 8'h25
`define RTS_CMD_RESET 8'h26
`define RTS_CMD_WR_AFI 8'h27
`define RTS_CMD_LK_AFI 8'h28
`define RTS_FLG_SEL 4
`define RTS_FLG_ADDR 5
`define RTS_FLG_OPT 6
`define RTS_RSP_OK 8'h00
`define RTS_RSP_ERR 8'h01
`define RTS_ERR_OPT 8'h03
`define RTS_ERR_RELOCK 8'h11
`define RTS_ERR_LOCKED 8'h12
`define RTS_ERR_PROG 8'h13
`define RTS_ERR_LOCKF 8'h14
// ************************
// frame and response lengths in bytes
// ************************
`define RTS_HDR_LEN 5'h02
`define RTS_UID_LEN 5'h08
`define RTS_LEN_OK 3'h3
`define RTS_LEN_ERR 3'h4
// ************************
// register map
// ************************
`define RTS_REG_CTRL 4'h0
`define RTS_REG_STAT 4'h4
`define RTS_REG_UIDL 4'h8
`define RTS_REG_UIDH 4'hC
`define RTS_CTRL_WIP 0
`define RTS_UID_RST 64'h0
// ************************
// timing
// ************************
`define RTS_CLK_NS 100
`define RTS_SLOT_NS 302000
`define RTS_SLOTS 18
`endif

/* inc/rts_pkg.sv */
/*
 * types of the tag select / family id command handler.
 * assumes nothing beyond a systemverilog compiler.
 */
package rts_pkg;
	typedef enum logic {TAG_READY, TAG_SELECTED} rts_tag_state_t;
	typedef enum logic [2:0] {SQ_IDLE, SQ_RX, SQ_T1, SQ_PROG, SQ_TX} rts_seq_t;
endpackage: rts_pkg

/* inc/rts_if.sv */
/*
 * carriers between the command handler and its frame and store modules.
 * assumes all parties run on ref_clk_i.
 */
`timescale 1ns/10ps
interface rts_frm_if;
	logic done;
	logic crc_ok;
	logic [4:0] nbytes;
	logic [7:0] flags;
	logic [7:0] cmd;
	logic [7:0] param;
	logic [63:0] uid;
	modport src(output done, crc_ok, nbytes, flags, cmd, param, uid);
	modport snk(input done, crc_ok, nbytes, flags, cmd, param, uid);
endinterface: rts_frm_if

interface rts_nvm_if;
	logic start;
	logic op_lock;
	logic fail_in;
	logic busy;
	logic done;
	logic fail;
	logic locked;
	logic [7:0] data;
	logic [7:0] app_family_id;
	modport ctl(output start, op_lock, data, fail_in, input busy, done, fail, locked, app_family_id);
	modport mem(input start, op_lock, data, fail_in, output busy, done, fail, locked, app_family_id);
endinterface: rts_nvm_if

/* src/rts_frame_rx.sv */
/*
 * collects a decoded request byte stream into command fields.
 * assumes bytes, sof and eof come from a decoder on ref_clk_i.
 */
`timescale 1ns/10ps
`include "rts_defines.svh"
module rts_frame_rx (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// decoded byte stream
	input wire logic sof_i,
	input wire logic vld_i,
	input wire logic [7:0] byte_i,
	input wire logic eof_i,
	input wire logic crc_ok_i,
	// frame fields
	rts_frm_if.src frm
);
	logic done_reg;
	logic crc_reg;
	logic [4:0] idx_reg;
	logic [7:0] flags_reg;
	logic [7:0] cmd_reg;
	logic [7:0] param_reg;
	logic [63:0] uid_reg;
	logic has_uid;

	// select always carries a uid
	assign has_uid = flags_reg[`RTS_FLG_ADDR] || (cmd_reg == `RTS_CMD_SELECT);

	// ************************
	// field capture
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idx_reg <= 5'h00;
			flags_reg <= 8'h00;
			cmd_reg <= 8'h00;
			param_reg <= 8'h00;
			uid_reg <= 64'h0;
		end else if (sof_i) begin
			idx_reg <= 5'h00;
		end else if (vld_i) begin
			if (idx_reg != 5'h1F) begin
				idx_reg <= idx_reg + 5'h01;
			end
			if (idx_reg == 5'h00) begin
				flags_reg <= byte_i;
			end else if (idx_reg == 5'h01) begin
				cmd_reg <= byte_i;
			end else if (has_uid && idx_reg < `RTS_HDR_LEN + `RTS_UID_LEN) begin
				uid_reg <= {byte_i, uid_reg[63:8]};
			end else begin
				param_reg <= byte_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done_reg <= 1'b0;
			crc_reg <= 1'b0;
		end else begin
			done_reg <= eof_i;
			if (eof_i) begin
				crc_reg <= crc_ok_i;
			end
		end
	end

	assign frm.done = done_reg;
	assign frm.crc_ok = crc_reg;
	assign frm.nbytes = idx_reg;
	assign frm.flags = flags_reg;
	assign frm.cmd = cmd_reg;
	assign frm.param = param_reg;
	assign frm.uid = uid_reg;
endmodule: rts_frame_rx

/* src/rts_nvm.sv */
/*
 * nonvolatile family id byte and its lock bit with the timed program cycle.
 * assumes start pulses only while busy is low; fail_in already synchronised.
 */
`timescale 1ns/10ps
`include "rts_defines.svh"
module rts_nvm #(
	parameter int PROG_CYC = 54360
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// store port
	rts_nvm_if.mem nvm
);
	logic busy_reg;
	logic done_reg;
	logic fail_reg;
	logic lock_reg;
	logic op_reg;
	logic [7:0] data_reg;
	logic [7:0] afi_reg;
	logic [31:0] cnt_reg;
	logic [31:0] len_q;

	// ************************
	// program cycle
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			op_reg <= 1'b0;
			data_reg <= 8'h00;
			cnt_reg <= 32'h0;
		end else begin
			done_reg <= 1'b0;
			if (nvm.start && !busy_reg) begin
				busy_reg <= 1'b1;
				cnt_reg <= 32'h0;
				op_reg <= nvm.op_lock;
				data_reg <= nvm.data;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg + 32'h1;
				if (cnt_reg == 32'(PROG_CYC - 1)) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
					fail_reg <= nvm.fail_in;
				end
			end
		end
	end

	// ************************
	// stored words
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			afi_reg <= 8'h00;
			lock_reg <= 1'b0;
		end else if (busy_reg && cnt_reg == 32'(PROG_CYC - 1) && !nvm.fail_in) begin
			if (op_reg) begin
				lock_reg <= 1'b1;
			end else if (!lock_reg) begin
				afi_reg <= data_reg;
			end
		end
	end

	assign nvm.busy = busy_reg;
	assign nvm.done = done_reg;
	assign nvm.fail = fail_reg;
	assign nvm.locked = lock_reg;
	assign nvm.app_family_id = afi_reg;

	// ************************
	// checks
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			len_q <= 32'h0;
		end else if (nvm.start && !busy_reg) begin
			len_q <= 32'h0;
		end else if (busy_reg) begin
			len_q <= len_q + 32'h1;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_prog_len;
		done_reg |-> len_q == 32'(PROG_CYC);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program cycle length wrong");

	property p_lock_hold;
		lock_reg |=> lock_reg && $stable(afi_reg);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked id changed");
endmodule: rts_nvm

/* src/rts_cmd.sv */
/*
 * command handler for select, reset to ready, family id write and lock.
 * assumes a decoder and response coder on ref_clk_i; prog_fail_i is a pin.
 */
`timescale 1ns/10ps
`include "rts_defines.svh"
// Notes on behaviour
// - select with own uid: become or stay selected, and reply
// - select with foreign uid: selected tag drops to ready, stays silent
// - select errors only on own uid; any error keeps the state
// - select and reset to ready answer option set with error 03h
// - reply is flags and crc; error reply adds one code byte
// - reset to ready moves to ready when no error occurs
// - addressed reset to ready answers only on own uid
// - family id write programs the supplied byte
// - family id lock makes the value permanent
// - program cycle lasts nominal delay plus 18 slots of 302 us
// - write error 12h when locked, 13h when programming fails with option set
// - lock error 11h when already locked, 14h when locking fails with option set
// - busy mode: pin low from request start to end of reply
// - progress mode: pin released for select and reset to ready
// - progress mode: pin low from request end to end of the program cycle
// - progress mode: pin released when a write is refused
module rts_cmd #(
	parameter int NOM_DLY_NS = 320000,
	parameter int PROG_CYC = (NOM_DLY_NS + `RTS_SLOTS * `RTS_SLOT_NS + `RTS_CLK_NS - 1)
		/ `RTS_CLK_NS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// request byte stream
	input wire logic rx_sof_i,
	input wire logic rx_byte_vld_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_eof_i,
	input wire logic rx_crc_ok_i,
	// response
	output logic tx_start_o,
	output logic [7:0] tx_flags_o,
	output logic [7:0] tx_code_o,
	output logic [2:0] tx_len_o,
	input wire logic tx_done_i,
	// program verify pin
	input wire logic prog_fail_i,
	// rf activity pin
	output logic act_o,
	output logic act_oe_n_o
);
	localparam int NOM_CYC = (NOM_DLY_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS;

	rts_frm_if frm ();
	rts_nvm_if nvm ();

	rts_pkg::rts_seq_t seq_reg, seq_next;
	rts_pkg::rts_tag_state_t tag_reg, tag_next;
	logic [31:0] t1_reg;
	logic [31:0] age_q;
	logic mode_wip_reg;
	logic [63:0] uid_reg;
	logic [31:0] rdata_reg;
	logic fail_s1, fail_s2;
	logic start_reg;
	logic [7:0] flags_reg, code_reg;
	logic [2:0] len_reg;
	logic oe_n_reg;
	logic ev_reply, ev_err, ev_prog, ev_defer;
	logic [7:0] ev_code;
	logic ok, match, addr_ok, sel_ok, opt, t1_hit;

	// ************************
	// helpers
	// ************************
	function automatic logic [4:0] exp_len(input logic [7:0] flg, input logic [7:0] cmd);
		logic [4:0] n;
		n = `RTS_HDR_LEN;
		if (flg[`RTS_FLG_ADDR] || cmd == `RTS_CMD_SELECT) begin
			n = n + `RTS_UID_LEN;
		end
		if (cmd == `RTS_CMD_WR_AFI) begin
			n = n + 5'h01;
		end
		return n;
	endfunction: exp_len

	rts_frame_rx u_rx (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.sof_i(rx_sof_i),
		.vld_i(rx_byte_vld_i),
		.byte_i(rx_byte_i),
		.eof_i(rx_eof_i),
		.crc_ok_i(rx_crc_ok_i),
		.frm(frm.src)
	);

	rts_nvm #(.PROG_CYC(PROG_CYC)) u_nvm (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.nvm(nvm.mem)
	);

	// ************************
	// verify pin sync
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fail_s1 <= 1'b0;
			fail_s2 <= 1'b0;
		end else begin
			fail_s1 <= prog_fail_i;
			fail_s2 <= fail_s1;
		end
	end

	assign nvm.fail_in = fail_s2;
	assign nvm.start = ev_prog;
	assign nvm.op_lock = (frm.cmd == `RTS_CMD_LK_AFI);
	assign nvm.data = frm.param;

	// ************************
	// request evaluation
	// ************************
	always_comb begin
		ok = frm.done && (seq_reg == rts_pkg::SQ_RX) && frm.crc_ok
			&& frm.nbytes == exp_len(frm.flags, frm.cmd);
		match = (frm.uid == uid_reg);
		addr_ok = !frm.flags[`RTS_FLG_ADDR] || match;
		sel_ok = !frm.flags[`RTS_FLG_SEL] || (tag_reg == rts_pkg::TAG_SELECTED);
		opt = frm.flags[`RTS_FLG_OPT];
		ev_reply = 1'b0;
		ev_err = 1'b0;
		ev_prog = 1'b0;
		ev_defer = 1'b0;
		ev_code = `RTS_ERR_OPT;
		tag_next = tag_reg;
		if (ok) begin
			case (frm.cmd)
				`RTS_CMD_SELECT: begin
					if (match) begin
						ev_reply = 1'b1;
						ev_err = opt;
						if (!opt) begin
							tag_next = rts_pkg::TAG_SELECTED;
						end
					end else begin
						tag_next = rts_pkg::TAG_READY;
					end
				end
				`RTS_CMD_RESET: begin
					if (addr_ok && sel_ok) begin
						ev_reply = 1'b1;
						ev_err = opt;
						if (!opt) begin
							tag_next = rts_pkg::TAG_READY;
						end
					end
				end
				`RTS_CMD_WR_AFI, `RTS_CMD_LK_AFI: begin
					if (addr_ok && sel_ok && !nvm.busy) begin
						ev_reply = 1'b1;
						if (nvm.locked) begin
							ev_err = 1'b1;
							ev_code = (frm.cmd == `RTS_CMD_LK_AFI) ? `RTS_ERR_RELOCK
								: `RTS_ERR_LOCKED;
						end else begin
							ev_prog = 1'b1;
							ev_defer = opt;
						end
					end
				end
				default: begin
					ev_reply = 1'b0;
				end
			endcase
		end
	end

	// ************************
	// sequencer
	// ************************
	assign t1_hit = (t1_reg == 32'(NOM_CYC - 1));

	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			rts_pkg::SQ_IDLE: begin
				if (rx_sof_i) begin
					seq_next = rts_pkg::SQ_RX;
				end
			end
			rts_pkg::SQ_RX: begin
				if (frm.done) begin
					if (!ev_reply) begin
						seq_next = rts_pkg::SQ_IDLE;
					end else if (ev_defer) begin
						seq_next = rts_pkg::SQ_PROG;
					end else begin
						seq_next = rts_pkg::SQ_T1;
					end
				end
			end
			rts_pkg::SQ_T1: begin
				if (t1_hit) begin
					seq_next = rts_pkg::SQ_TX;
				end
			end
			rts_pkg::SQ_PROG: begin
				if (nvm.done) begin
					seq_next = rts_pkg::SQ_TX;
				end
			end
			rts_pkg::SQ_TX: begin
				if (tx_done_i) begin
					seq_next = rts_pkg::SQ_IDLE;
				end
			end
			default: begin
				seq_next = rts_pkg::SQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seq_reg <= rts_pkg::SQ_IDLE;
			tag_reg <= rts_pkg::TAG_READY;
		end else begin
			seq_reg <= seq_next;
			tag_reg <= tag_next;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			t1_reg <= 32'h0;
		end else if (seq_reg == rts_pkg::SQ_T1) begin
			t1_reg <= t1_reg + 32'h1;
		end else begin
			t1_reg <= 32'h0;
		end
	end

	// ************************
	// response
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_reg <= 1'b0;
			flags_reg <= `RTS_RSP_OK;
			code_reg <= 8'h00;
			len_reg <= `RTS_LEN_OK;
		end else begin
			start_reg <= (seq_reg == rts_pkg::SQ_T1 && t1_hit)
				|| (seq_reg == rts_pkg::SQ_PROG && nvm.done);
			if (ev_reply) begin
				flags_reg <= ev_err ? `RTS_RSP_ERR : `RTS_RSP_OK;
				code_reg <= ev_err ? ev_code : 8'h00;
				len_reg <= ev_err ? `RTS_LEN_ERR : `RTS_LEN_OK;
			end else if (seq_reg == rts_pkg::SQ_PROG && nvm.done && nvm.fail) begin
				flags_reg <= `RTS_RSP_ERR;
				code_reg <= nvm.op_lock ? `RTS_ERR_LOCKF : `RTS_ERR_PROG;
				len_reg <= `RTS_LEN_ERR;
			end
		end
	end

	// ************************
	// activity pin
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			oe_n_reg <= 1'b1;
		end else if (mode_wip_reg) begin
			oe_n_reg <= !(nvm.busy || ev_prog);
		end else begin
			oe_n_reg <= (seq_next == rts_pkg::SQ_IDLE);
		end
	end

	// ************************
	// registers
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_wip_reg <= 1'b0;
			uid_reg <= `RTS_UID_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`RTS_REG_CTRL: mode_wip_reg <= reg_wdata_i[`RTS_CTRL_WIP];
				`RTS_REG_UIDL: uid_reg[31:0] <= reg_wdata_i;
				`RTS_REG_UIDH: uid_reg[63:32] <= reg_wdata_i;
				default: uid_reg <= uid_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= 32'h0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`RTS_REG_CTRL: rdata_reg <= {31'h0, mode_wip_reg};
				`RTS_REG_STAT: rdata_reg <= {16'h0, nvm.app_family_id, 5'h00, nvm.busy,
					nvm.locked, tag_reg == rts_pkg::TAG_SELECTED};
				`RTS_REG_UIDL: rdata_reg <= uid_reg[31:0];
				`RTS_REG_UIDH: rdata_reg <= uid_reg[63:32];
				default: rdata_reg <= 32'h0;
			endcase
		end else begin
			rdata_reg <= 32'h0;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign tx_start_o = start_reg;
	assign tx_flags_o = flags_reg;
	assign tx_code_o = code_reg;
	assign tx_len_o = len_reg;
	assign act_oe_n_o = oe_n_reg;
	assign act_o = oe_n_reg;

	// ************************
	// checks
	// ************************
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			age_q <= 32'h0;
		end else if (frm.done) begin
			age_q <= 32'h0;
		end else begin
			age_q <= age_q + 32'h1;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_sel_own;
		ok && frm.cmd == `RTS_CMD_SELECT && match && !opt
			|=> tag_reg == rts_pkg::TAG_SELECTED;
	endproperty
	a_sel_own: assert property (p_sel_own) else $error("select did not select");

	property p_sel_other;
		ok && frm.cmd == `RTS_CMD_SELECT && !match
			|=> tag_reg == rts_pkg::TAG_READY && !tx_start_o [*3];
	endproperty
	a_sel_other: assert property (p_sel_other) else $error("foreign select answered");

	property p_err_keep;
		ev_reply && ev_err |=> tag_reg == $past(tag_reg);
	endproperty
	a_err_keep: assert property (p_err_keep) else $error("state moved on error");

	property p_len;
		tx_start_o |-> tx_len_o == ((tx_flags_o == `RTS_RSP_ERR) ? `RTS_LEN_ERR : `RTS_LEN_OK);
	endproperty
	a_len: assert property (p_len) else $error("reply length wrong");

	property p_t1;
		tx_start_o && $past(seq_reg) == rts_pkg::SQ_T1 |-> age_q == 32'(NOM_CYC);
	endproperty
	a_t1: assert property (p_t1) else $error("reply delay wrong");

	property p_busy_pin;
		!mode_wip_reg && seq_reg == rts_pkg::SQ_TX && !tx_done_i |=> !act_oe_n_o;
	endproperty
	a_busy_pin: assert property (p_busy_pin) else $error("busy pin released early");

	property p_wip_pin;
		mode_wip_reg && !nvm.busy && !ev_prog |=> act_oe_n_o || !mode_wip_reg;
	endproperty
	a_wip_pin: assert property (p_wip_pin) else $error("progress pin driven");

	property p_locked_wr;
		ok && frm.cmd == `RTS_CMD_WR_AFI && nvm.locked && ev_reply
			|=> code_reg == `RTS_ERR_LOCKED && !nvm.busy;
	endproperty
	a_locked_wr: assert property (p_locked_wr) else $error("locked write accepted");

	c_select: cover property (ok && frm.cmd == `RTS_CMD_SELECT && match);
	c_defer: cover property (seq_reg == rts_pkg::SQ_PROG && nvm.done);
	c_locked: cover property (ok && nvm.locked && ev_reply);
endmodule: rts_cmd

/* verif/rts_reader.sv */
/*
 * reader model: sends decoded request frames byte by byte and ends each reply.
 * assumes the handler and the bench share ref_clk_i.
 */
`timescale 1ns/10ps
module rts_reader (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// request stream
	output logic sof_o,
	output logic vld_o,
	output logic [7:0] byte_o,
	output logic eof_o,
	output logic crc_ok_o,
	// reply
	input wire logic tx_start_i,
	output logic tx_done_o
);
	// ************************
	// reply end after a settable delay
	// ************************
	int rsp_cyc = 4;
	int cnt = 0;
	initial begin
		sof_o = 1'b0;
		vld_o = 1'b0;
		byte_o = 8'h00;
		eof_o = 1'b0;
		crc_ok_o = 1'b0;
		tx_done_o = 1'b0;
	end
	always @(posedge ref_clk_i) begin
		tx_done_o <= resetn_i && (cnt == 1);
		if (!resetn_i) cnt <= 0;
		else if (tx_start_i) cnt <= rsp_cyc;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	// ************************
	// one request frame
	// ************************
	task automatic send(input logic [7:0] f, input logic [7:0] c, input logic [63:0] u,
		input logic [7:0] p, input logic pe, input logic crc);
		logic [7:0] b[$];
		b = {f, c};
		if (f[5] || c == 8'h25) for (int i = 0; i < 8; i++) b.push_back(u[8*i+:8]);
		if (pe) b.push_back(p);
		@(posedge ref_clk_i);
		sof_o <= 1'b1;
		foreach (b[i]) begin
			@(posedge ref_clk_i);
			sof_o <= 1'b0;
			vld_o <= 1'b1;
			byte_o <= b[i];
		end
		@(posedge ref_clk_i);
		vld_o <= 1'b0;
		byte_o <= ~byte_o;
		eof_o <= 1'b1;
		crc_ok_o <= crc;
		@(posedge ref_clk_i);
		eof_o <= 1'b0;
		crc_ok_o <= 1'b0;
	endtask: send
endmodule: rts_reader

/* verif/tb.sv */
/*
 * testbench: register calls and reader requests with expected replies.
 * assumes rts_cmd with a short nominal delay and program cycle.
 */
`timescale 1ns/10ps
module tb;
	// ************************
	// signals and instances
	// ************************
	localparam int NOM = 10;
	localparam int PROG = 30;
	localparam logic [63:0] UID = 64'h0123456789ABCDEF;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic prog_fail_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic sof, vld, eof, crc_ok, tx_start_o, tx_done, act_o, act_oe_n_o, act_low;
	logic [7:0] rx_byte, tx_flags_o, tx_code_o;
	logic [2:0] tx_len_o;
	logic act_bad = 1'b0;
	int num_errors = 0;
	int checks = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (act_oe_n_o === 1'b0) act_low <= 1'b1;
	always @(posedge ref_clk_i) if (act_oe_n_o === 1'b0 && act_o !== 1'b0) act_bad <= 1'b1;
	rts_cmd #(.NOM_DLY_NS(1000), .PROG_CYC(PROG)) i_rts_cmd (.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.rx_sof_i(sof), .rx_byte_vld_i(vld), .rx_byte_i(rx_byte), .rx_eof_i(eof),
		.rx_crc_ok_i(crc_ok), .tx_start_o(tx_start_o), .tx_flags_o(tx_flags_o),
		.tx_code_o(tx_code_o), .tx_len_o(tx_len_o), .tx_done_i(tx_done),
		.prog_fail_i(prog_fail_i), .act_o(act_o), .act_oe_n_o(act_oe_n_o));
	rts_reader i_rts_reader (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .sof_o(sof),
		.vld_o(vld), .byte_o(rx_byte), .eof_o(eof), .crc_ok_o(crc_ok),
		.tx_start_i(tx_start_o), .tx_done_o(tx_done));
	// ************************
	// tasks
	// ************************
	task automatic final_report;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask: final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask: chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask: wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o & msk, exp);
	endtask: rd
	// n = 0: no reply expected; a: activity pin expected low at some point
	task automatic req(input logic [7:0] f, input logic [7:0] c, input logic [63:0] u,
		input logic [7:0] p, input logic crc, input int n, input logic [7:0] code,
		input logic a);
		int k;
		k = 0;
		act_low = 1'b0;
		i_rts_reader.send(f, c, u, p, c == 8'h27, crc);
		while (tx_start_o !== 1'b1 && k < PROG + 20) begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
		chk(32'(k), 32'((n == 0) ? PROG + 20 : n));
		if (n != 0) begin
			if (k >= PROG + 20) final_report();
			chk({tx_flags_o, tx_code_o, 13'h0, tx_len_o}, {(code != 8'h00) ? 8'h01 : 8'h00,
				code, 13'h0, (code != 8'h00) ? 3'h4 : 3'h3});
			repeat (i_rts_reader.rsp_cyc + 3) @(posedge ref_clk_i);
		end
		chk({31'h0, act_low}, {31'h0, a});
		chk({31'h0, act_bad}, 32'h0);
	endtask: req
	// ************************
	// sequence
	// ************************
	initial begin
		act_low = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rd(4'h4, 32'h00000000, 32'h0000FFFF);
		wr(4'h8, UID[31:0]);
		wr(4'hC, UID[63:32]);
		rd(4'hC, UID[63:32], 32'hFFFFFFFF);
		rd(4'h2, 32'h00000000, 32'hFFFFFFFF);
		$display("test registers done");
		req(8'h20, 8'h25, UID, 8'h00, 1'b1, NOM + 1, 8'h00, 1'b1);
		rd(4'h4, 32'h00000001, 32'h00000001);
		req(8'h60, 8'h25, UID, 8'h00, 1'b1, NOM + 1, 8'h03, 1'b1);
		rd(4'h4, 32'h00000001, 32'h00000001);
		req(8'h20, 8'h25, ~UID, 8'h00, 1'b1, 0, 8'h00, 1'b1);
		rd(4'h4, 32'h00000000, 32'h00000001);
		req(8'h20, 8'h25, UID, 8'h00, 1'b0, 0, 8'h00, 1'b1);
		req(8'h20, 8'h25, UID, 8'h00, 1'b1, NOM + 1, 8'h00, 1'b1);
		req(8'h00, 8'h26, UID, 8'h00, 1'b1, NOM + 1, 8'h00, 1'b1);
		rd(4'h4, 32'h00000000, 32'h00000001);
		req(8'h60, 8'h26, ~UID, 8'h00, 1'b1, 0, 8'h00, 1'b1);
		req(8'h60, 8'h26, UID, 8'h00, 1'b1, NOM + 1, 8'h03, 1'b1);
		$display("test select and reset done");
		wr(4'h0, 32'h00000001);
		req(8'h20, 8'h25, UID, 8'h00, 1'b1, NOM + 1, 8'h00, 1'b0);
		req(8'h00, 8'h26, UID, 8'h00, 1'b1, NOM + 1, 8'h00, 1'b0);
		req(8'h00, 8'h27, UID, 8'hA5, 1'b1, NOM + 1, 8'h00, 1'b1);
		repeat (PROG) @(posedge ref_clk_i);
		rd(4'h4, 32'h0000A500, 32'h0000FF06);
		@(posedge ref_clk_i);
		prog_fail_i <= 1'b1;
		req(8'h40, 8'h27, UID, 8'h77, 1'b1, PROG + 2, 8'h13, 1'b1);
		@(posedge ref_clk_i);
		prog_fail_i <= 1'b0;
		req(8'h40, 8'h27, UID, 8'h3C, 1'b1, PROG + 2, 8'h00, 1'b1);
		rd(4'h4, 32'h00003C00, 32'h0000FF06);
		$display("test write done");
		@(posedge ref_clk_i);
		prog_fail_i <= 1'b1;
		req(8'h40, 8'h28, UID, 8'h00, 1'b1, PROG + 2, 8'h14, 1'b1);
		@(posedge ref_clk_i);
		prog_fail_i <= 1'b0;
		rd(4'h4, 32'h00000000, 32'h00000002);
		req(8'h40, 8'h28, UID, 8'h00, 1'b1, PROG + 2, 8'h00, 1'b1);
		rd(4'h4, 32'h00000002, 32'h00000002);
		req(8'h00, 8'h28, UID, 8'h00, 1'b1, NOM + 1, 8'h11, 1'b0);
		req(8'h00, 8'h27, UID, 8'h99, 1'b1, NOM + 1, 8'h12, 1'b0);
		wr(4'h0, 32'h00000000);
		req(8'h00, 8'h27, UID, 8'h55, 1'b1, NOM + 1, 8'h12, 1'b1);
		rd(4'h4, 32'h00003C02, 32'h0000FF06);
		$display("test lock done");
		final_report();
	end
endmodule: tb
